// file: rtl/mon_bank.sv
// one security space's bank of bandwidth usage monitors
`timescale 1ns/10ps
module mon_bank
  import frame_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register access, already decoded
  input wire logic [MON_W-1:0] sel,
  input wire logic wr_en,
  input wire reg_sel_t rsel,
  input wire logic [31:0] wdata,
  input wire logic capt,
  // traffic
  input wire mon_evt_t evt,
  input wire logic evt_hit,
  // read data of the selected instance
  output logic [31:0] rdata
);
  logic [31:0] flt_q [NUM_MON];
  logic [31:0] flt_d [NUM_MON];
  logic [31:0] ctl_q [NUM_MON];
  logic [31:0] ctl_d [NUM_MON];
  logic [31:0] cnt_q [NUM_MON];
  logic [31:0] cnt_d [NUM_MON];
  logic [31:0] cap_q [NUM_MON];
  logic [31:0] cap_d [NUM_MON];

  // software writes first, then counting, so a hardware overflow set wins
  always_comb begin
    logic match;
    logic [32:0] sum;
    logic sw_cnt;
    match = 1'b0;
    sum = '0;
    sw_cnt = 1'b0;
    flt_d = flt_q;
    ctl_d = ctl_q;
    cnt_d = cnt_q;
    cap_d = cap_q;
    if (wr_en) begin
      case (rsel)
        SEL_FLT: flt_d[sel] = wdata & FLT_WMASK;
        SEL_CTL: ctl_d[sel] = (wdata & CTL_WMASK) | CTL_TYPE_VAL;
        SEL_CNT: cnt_d[sel] = wdata;
        default: ;
      endcase
    end
    for (int i = 0; i < NUM_MON; i++) begin
      sw_cnt = wr_en && rsel == SEL_CNT && sel == MON_W'(i);
      match = evt.valid && evt_hit && ctl_q[i][CTL_EN]
        && (!ctl_q[i][CTL_MPART] || evt.partition_identifier == flt_q[i][15:0])
        && (!ctl_q[i][CTL_MPMG] || evt.monitoring_group == flt_q[i][23:16]);
      sum = {1'b0, cnt_q[i]} + {17'h0_0000, evt.bytes};
      // a frozen counter stays put once it has overflowed
      if (match && !sw_cnt && !(ctl_q[i][CTL_FRZ] && ctl_q[i][CTL_OFL])) begin
        cnt_d[i] = sum[31:0];
        if (sum[32]) begin
          ctl_d[i][CTL_OFL] = 1'b1;
        end
      end
      // local capture copies the live count, optional reset after
      if (capt && ctl_q[i][CTL_EVT_LSB+:3] == EVT_LOCAL) begin
        cap_d[i] = cnt_q[i];
        if (ctl_q[i][CTL_CRST]) begin
          cnt_d[i] = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_MON; i++) begin
        flt_q[i] <= '0;
        ctl_q[i] <= CTL_TYPE_VAL;
        cnt_q[i] <= '0;
        cap_q[i] <= '0;
      end
    end else begin
      flt_q <= flt_d;
      ctl_q <= ctl_d;
      cnt_q <= cnt_d;
      cap_q <= cap_d;
    end
  end

  // reads follow the bank's own monitor selector
  always_comb begin
    rdata = '0;
    case (rsel)
      SEL_FLT: rdata = flt_q[sel];
      SEL_CTL: rdata = ctl_q[sel];
      SEL_CNT: rdata = cnt_q[sel];
      SEL_CAPTURE: rdata = cap_q[sel];
      default: rdata = '0;
    endcase
  end
endmodule : mon_bank

// file: rtl/part_mon_frame.sv
// register frame for partition configuration and resource monitoring
`timescale 1ns/10ps
module part_mon_frame
  import frame_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register access from processor software
  input wire bus_req_t req,
  output bus_rsp_t rsp,
  // monitored traffic
  input wire mon_evt_t evt
);
  // bank index: 0 non-secure, 1 secure
  localparam logic BANK_S = 1'b1;
  localparam logic BANK_NS = 1'b0;

  // offset to register, absent ones fold to reserved
  function automatic reg_sel_t decode(input logic [15:0] off, input logic sec);
    reg_sel_t s;
    s = SEL_NONE;
    case (off)
      OFF_IDR: s = SEL_IDR;
      OFF_SIDR: s = sec ? SEL_SIDR : SEL_NONE;
      OFF_IIDR: s = SEL_IIDR;
      OFF_AIDR: s = SEL_AIDR;
      OFF_CCAP_IDR: s = SEL_CCAP_IDR;
      OFF_PRI_IDR: s = sec ? SEL_NONE : SEL_PRI_IDR;
      OFF_MONITOR_REGS_IDR: s = SEL_MONITOR_REGS_IDR;
      OFF_MBWU_IDR: s = SEL_MBWU_IDR;
      OFF_ECR: s = SEL_ECR;
      OFF_ESR: s = SEL_ESR;
      OFF_PART_SEL: s = SEL_PART_SEL;
      OFF_CMAX: s = SEL_CMAX;
      OFF_PRI: s = sec ? SEL_NONE : SEL_PRI;
      OFF_MON_SEL: s = SEL_MON_SEL;
      OFF_CAPT: s = SEL_CAPT;
      OFF_FLT: s = SEL_FLT;
      OFF_CTL: s = SEL_CTL;
      OFF_CNT: s = SEL_CNT;
      OFF_CAPTURE: s = SEL_CAPTURE;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // request decode
  logic page_hit;
  logic sec;
  logic bank;
  logic wr;
  reg_sel_t sel;

  // the page check keeps every register of the frame in one aligned block
  assign page_hit = req.addr[31:16] == FRAME_PAGE;
  // both spaces reach the page; the flag picks the bank and hides the registers of the other space
  assign sec = ~req.ns;
  assign bank = sec ? BANK_S : BANK_NS;
  assign wr = req.valid && req.write && page_hit;
  assign sel = decode(req.addr[15:0], sec);

  // banked partition selectors, cmax and error registers; one unbanked pri set
  logic [PART_W-1:0] part_sel_q [2];
  logic [PART_W-1:0] part_sel_d [2];
  logic [MON_W-1:0] mon_sel_q [2];
  logic [MON_W-1:0] mon_sel_d [2];
  logic [7:0] cmax_q [2][NUM_PART];
  logic [7:0] cmax_d [2][NUM_PART];
  logic [3:0] pri_q [NUM_PART];
  logic [3:0] pri_d [NUM_PART];
  logic [31:0] ecr_q [2];
  logic [31:0] ecr_d [2];
  logic [31:0] esr_q [2];
  logic [31:0] esr_d [2];

  // writes land only in the bank of the access; other bank untouched
  always_comb begin
    part_sel_d = part_sel_q;
    mon_sel_d = mon_sel_q;
    cmax_d = cmax_q;
    pri_d = pri_q;
    ecr_d = ecr_q;
    esr_d = esr_q;
    if (wr) begin
      case (sel)
        SEL_PART_SEL: begin
          // an out-of-range partition is refused and logged, selector kept
          if (req.wdata[15:0] > PARTITION_IDENTIFIER_MAX) begin
            esr_d[bank] = {4'h0, ERR_PART_RANGE, 8'h00, req.wdata[15:0]};
          end else begin
            part_sel_d[bank] = req.wdata[PART_W-1:0];
          end
        end
        SEL_MON_SEL: begin
          if (req.wdata[15:0] >= MON_COUNT) begin
            esr_d[bank] = {4'h0, ERR_MON_RANGE, 8'h00, req.wdata[15:0]};
          end else begin
            mon_sel_d[bank] = req.wdata[MON_W-1:0];
          end
        end
        SEL_CMAX: cmax_d[bank][part_sel_q[bank]] = req.wdata[7:0] & CMAX_WMASK[7:0];
        SEL_PRI: pri_d[part_sel_q[bank]] = req.wdata[3:0] & PRI_WMASK[3:0];
        SEL_ECR: ecr_d[bank] = req.wdata & ECR_WMASK;
        SEL_ESR: esr_d[bank] = req.wdata;
        // identification registers and reserved locations drop writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 2; b++) begin
        part_sel_q[b] <= '0;
        mon_sel_q[b] <= '0;
        ecr_q[b] <= '0;
        esr_q[b] <= '0;
        for (int p = 0; p < NUM_PART; p++) begin
          cmax_q[b][p] <= '0;
        end
      end
      for (int p = 0; p < NUM_PART; p++) begin
        pri_q[p] <= '0;
      end
    end else begin
      part_sel_q <= part_sel_d;
      mon_sel_q <= mon_sel_d;
      cmax_q <= cmax_d;
      pri_q <= pri_d;
      ecr_q <= ecr_d;
      esr_q <= esr_d;
    end
  end

  // local capture: non-secure write hits its own monitors,
  // secure write with the all bit hits both banks
  logic capt_go;
  logic [1:0] capt;
  assign capt_go = wr && sel == SEL_CAPT && req.wdata[CAPT_NOW];
  assign capt[BANK_NS] = capt_go && (!sec || req.wdata[CAPT_ALL]);
  assign capt[BANK_S] = capt_go && sec;

  // one monitor bank per security space
  logic [31:0] mon_rdata [2];
  for (genvar g = 0; g < 2; g++) begin : g_mon
    mon_bank u_bank (
      .core_clk(core_clk),
      .rst(rst),
      .sel(mon_sel_q[g]),
      .wr_en(wr && bank == 1'(g)),
      .rsel(sel),
      .wdata(req.wdata),
      .capt(capt[g]),
      .evt(evt),
      .evt_hit(evt.ns != 1'(g)),
      .rdata(mon_rdata[g])
    );
  end

  // read mux; absent and unallocated locations read zero
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (sel)
      SEL_IDR: rdata = sec ? IDR_S_VAL : IDR_NS_VAL;
      SEL_SIDR: rdata = SIDR_VAL;
      SEL_IIDR: rdata = IIDR_VAL;
      SEL_AIDR: rdata = AIDR_VAL;
      SEL_CCAP_IDR: rdata = CCAP_IDR_VAL;
      SEL_PRI_IDR: rdata = PRI_IDR_VAL;
      SEL_MONITOR_REGS_IDR: rdata = MONITOR_REGS_IDR_VAL;
      SEL_MBWU_IDR: rdata = MBWU_IDR_VAL;
      SEL_ECR: rdata = ecr_q[bank];
      SEL_ESR: rdata = esr_q[bank];
      SEL_PART_SEL: rdata = 32'(part_sel_q[bank]);
      SEL_MON_SEL: rdata = 32'(mon_sel_q[bank]);
      SEL_CMAX: rdata = 32'(cmax_q[bank][part_sel_q[bank]]);
      SEL_PRI: rdata = 32'(pri_q[part_sel_q[bank]]);
      SEL_FLT: rdata = mon_rdata[bank];
      SEL_CTL: rdata = mon_rdata[bank];
      SEL_CNT: rdata = mon_rdata[bank];
      SEL_CAPTURE: rdata = mon_rdata[bank];
      default: rdata = '0;
    endcase
  end

  // answer one cycle after every request, from a flop
  bus_rsp_t rsp_q;
  bus_rsp_t rsp_d;
  always_comb begin
    rsp_d.valid = req.valid;
    rsp_d.hit = req.valid && page_hit;
    rsp_d.rdata = (req.valid && !req.write && page_hit) ? rdata : 32'h0000_0000;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;
endmodule : part_mon_frame

// file: shared/frame_pkg.sv
// shared constants and types for the partitioning and monitoring register frame
package frame_pkg;
  // frame placement: 64 KB page, page index compared against addr[31:16]
  localparam logic [15:0] FRAME_PAGE = 16'h4000;
  localparam logic [15:0] IMPL_BASE = 16'h3000;
  // register offsets inside the page
  localparam logic [15:0] OFF_IDR = 16'h0000;
  localparam logic [15:0] OFF_SIDR = 16'h0008;
  localparam logic [15:0] OFF_IIDR = 16'h0018;
  localparam logic [15:0] OFF_AIDR = 16'h0020;
  localparam logic [15:0] OFF_CCAP_IDR = 16'h0038;
  localparam logic [15:0] OFF_PRI_IDR = 16'h0048;
  localparam logic [15:0] OFF_MONITOR_REGS_IDR = 16'h0080;
  localparam logic [15:0] OFF_MBWU_IDR = 16'h0090;
  localparam logic [15:0] OFF_ECR = 16'h00f0;
  localparam logic [15:0] OFF_ESR = 16'h00f8;
  localparam logic [15:0] OFF_PART_SEL = 16'h0100;
  localparam logic [15:0] OFF_CMAX = 16'h0108;
  localparam logic [15:0] OFF_PRI = 16'h0400;
  localparam logic [15:0] OFF_MON_SEL = 16'h0800;
  localparam logic [15:0] OFF_CAPT = 16'h0808;
  localparam logic [15:0] OFF_FLT = 16'h0820;
  localparam logic [15:0] OFF_CTL = 16'h0828;
  localparam logic [15:0] OFF_CNT = 16'h0860;
  localparam logic [15:0] OFF_CAPTURE = 16'h0868;
  // sizes
  localparam int NUM_PART = 8;
  localparam int NUM_MON = 4;
  localparam int PART_W = 3;
  localparam int MON_W = 2;
  localparam logic [15:0] PARTITION_IDENTIFIER_MAX = 16'h0007;
  localparam logic [7:0] PMG_MAX = 8'h01;
  localparam logic [15:0] MON_COUNT = 16'h0004;
  // feature identification: [15:0] partition_identifier max, [23:16] pmg max, 24 ccap, 25 pri, 26 monitors
  localparam logic [31:0] IDR_NS_VAL = {5'h00, 1'b1, 1'b1, 1'b1, PMG_MAX, PARTITION_IDENTIFIER_MAX};
  localparam logic [31:0] IDR_S_VAL = {5'h00, 1'b1, 1'b0, 1'b1, PMG_MAX, PARTITION_IDENTIFIER_MAX};
  localparam logic [31:0] SIDR_VAL = {8'h00, PMG_MAX, PARTITION_IDENTIFIER_MAX};
  // arbitrary implementation code, no meaning
  localparam logic [31:0] IIDR_VAL = 32'h0000_0a5a;
  localparam logic [31:0] AIDR_VAL = 32'h0000_0010;
  localparam logic [31:0] CCAP_IDR_VAL = 32'h0000_0008;
  localparam logic [31:0] PRI_IDR_VAL = 32'h0000_0004;
  // monitor types: bit 17 bandwidth usage, bit 31 local capture event
  localparam logic [31:0] MONITOR_REGS_IDR_VAL = 32'h8002_0000;
  // [15:0] instance count, bit 31 capture present
  localparam logic [31:0] MBWU_IDR_VAL = {16'h8000, MON_COUNT};
  // monitor control fields
  localparam logic [31:0] CTL_TYPE_VAL = 32'h0000_0042;
  localparam logic [31:0] CTL_WMASK = 32'hfff3_0000;
  localparam int CTL_MPART = 16;
  localparam int CTL_MPMG = 17;
  localparam int CTL_FRZ = 24;
  localparam int CTL_OFL = 26;
  localparam int CTL_CRST = 27;
  localparam int CTL_EVT_LSB = 28;
  localparam int CTL_EN = 31;
  localparam logic [2:0] EVT_LOCAL = 3'h7;
  localparam logic [31:0] FLT_WMASK = 32'h00ff_ffff;
  // capture event register bits
  localparam int CAPT_NOW = 0;
  localparam int CAPT_ALL = 1;
  // error status: [15:0] index, [27:24] code
  localparam logic [3:0] ERR_PART_RANGE = 4'h1;
  localparam logic [3:0] ERR_MON_RANGE = 4'h2;
  localparam logic [31:0] ECR_WMASK = 32'h0000_0001;
  localparam logic [31:0] CMAX_WMASK = 32'h0000_00ff;
  localparam logic [31:0] PRI_WMASK = 32'h0000_000f;

  typedef enum logic [4:0] {
    SEL_NONE, SEL_IDR, SEL_SIDR, SEL_IIDR, SEL_AIDR, SEL_CCAP_IDR, SEL_PRI_IDR,
    SEL_MONITOR_REGS_IDR, SEL_MBWU_IDR, SEL_ECR, SEL_ESR, SEL_PART_SEL, SEL_CMAX, SEL_PRI,
    SEL_MON_SEL, SEL_CAPT, SEL_FLT, SEL_CTL, SEL_CNT, SEL_CAPTURE
  } reg_sel_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic ns;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] rdata;
  } bus_rsp_t;

  typedef struct packed {
    logic valid;
    logic ns;
    logic [15:0] partition_identifier;
    logic [7:0] monitoring_group;
    logic [15:0] bytes;
  } mon_evt_t;
endpackage : frame_pkg

// file: testbench/frame_asserts.sv
// assertions on the register bus port of the frame
`timescale 1ns/10ps
module frame_asserts
  import frame_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire bus_req_t req,
  input wire bus_rsp_t rsp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // a read of one page offset from one space
  sequence s_rd(logic [15:0] off, logic sp);
    req.valid && !req.write && req.addr == {FRAME_PAGE, off} && req.ns == sp;
  endsequence
  // any request that lands in the page
  sequence s_in_page;
    req.valid && req.addr[31:16] == FRAME_PAGE;
  endsequence

  a_page_answers: assert property (s_in_page |=> rsp.valid && rsp.hit)
    else $error("page access not answered in one cycle");
  a_miss_zero: assert property (req.valid && req.addr[31:16] != FRAME_PAGE |=>
      rsp.valid && !rsp.hit && rsp.rdata == 32'h0)
    else $error("access outside page not refused");
  a_idr_ns: assert property (s_rd(OFF_IDR, 1'b1) |=> rsp.rdata == IDR_NS_VAL)
    else $error("feature id wrong for non-secure");
  a_idr_sec: assert property (s_rd(OFF_IDR, 1'b0) |=> rsp.rdata == IDR_S_VAL)
    else $error("feature id wrong for secure");
  a_sidr_secure: assert property (s_rd(OFF_SIDR, 1'b0) |=> rsp.rdata == SIDR_VAL)
    else $error("secure id wrong");
  a_sidr_hidden: assert property (s_rd(OFF_SIDR, 1'b1) |=> rsp.hit && rsp.rdata == 32'h0)
    else $error("secure id visible to non-secure");
  a_iidr_shared: assert property (s_rd(OFF_IIDR, req.ns) |=> rsp.rdata == IIDR_VAL)
    else $error("implementation id differs");
  a_aidr_shared: assert property (s_rd(OFF_AIDR, req.ns) |=> rsp.rdata == AIDR_VAL)
    else $error("architecture id differs");
  a_types_list: assert property (s_rd(OFF_MONITOR_REGS_IDR, req.ns) |=> rsp.rdata == MONITOR_REGS_IDR_VAL)
    else $error("monitor type list wrong");
  a_pri_absent: assert property (s_rd(OFF_PRI, 1'b0) |=> rsp.rdata == 32'h0)
    else $error("one-space control seen from secure");
  a_impl_zero: assert property (s_in_page ##0 req.addr[15:12] >= 4'h3 |=> rsp.rdata == 32'h0)
    else $error("implementation region not zero");
endmodule : frame_asserts

// file: testbench/testbench.sv
// self-checking bench for the partitioning and monitoring frame
`timescale 1ns/10ps
module testbench
  import frame_pkg::*;
;
  localparam logic nsp = 1'b1;
  localparam logic sec = 1'b0;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_t req = '0;
  bus_rsp_t rsp;
  mon_evt_t evt;
  int bad_count = 0;
  int n_tests = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  part_mon_frame dut_u (.core_clk(core_clk), .rst(rst), .req(req), .rsp(rsp), .evt(evt));
  traffic_src src_u (.core_clk(core_clk), .evt(evt));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one request; answer sampled once its single-cycle slot has settled
  task automatic acc(input logic w, input logic sp, input logic [31:0] a,
      input logic [31:0] wd, output bus_rsp_t r);
    @(posedge core_clk);
    req <= '{valid: 1'b1, write: w, ns: sp, addr: a, wdata: wd};
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1;
    r = rsp;
  endtask : acc

  task automatic wr(input logic sp, input logic [15:0] o, input logic [31:0] d);
    bus_rsp_t r;
    acc(1'b1, sp, {FRAME_PAGE, o}, d, r);
  endtask : wr

  task automatic rd(input logic sp, input logic [15:0] o, input logic [31:0] e, input string n);
    bus_rsp_t r;
    acc(1'b0, sp, {FRAME_PAGE, o}, 32'h0, r);
    chk(n, r.rdata, e);
  endtask : rd

  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // watchdog, far beyond the roughly 160 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge core_clk);
    bad_count++;
    test_done();
  end

  // main sequence; one thread, so each select-then-access run is never interleaved
  initial begin
    bus_rsp_t r;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    // discovery
    rd(nsp, OFF_IDR, IDR_NS_VAL, "idr ns");
    rd(sec, OFF_IDR, IDR_S_VAL, "idr s");
    rd(nsp, OFF_SIDR, 32'h0, "sidr ns");
    rd(sec, OFF_SIDR, SIDR_VAL, "sidr s");
    for (int i = 0; i < 2; i++) begin
      rd(1'(i), OFF_IIDR, IIDR_VAL, "iidr");
      rd(1'(i), OFF_AIDR, AIDR_VAL, "aidr");
      rd(1'(i), OFF_CCAP_IDR, CCAP_IDR_VAL, "ccap idr");
      rd(1'(i), OFF_MONITOR_REGS_IDR, MONITOR_REGS_IDR_VAL, "mon types");
      rd(1'(i), OFF_MBWU_IDR, MBWU_IDR_VAL, "mbwu idr");
    end
    rd(nsp, OFF_PRI_IDR, PRI_IDR_VAL, "pri idr ns");
    rd(sec, OFF_PRI_IDR, 32'h0, "pri idr s");
    // partition settings, banked per space except pri, which only the non-secure space reaches
    wr(nsp, OFF_PART_SEL, 32'h3);
    wr(nsp, OFF_CMAX, 32'habcd);
    wr(nsp, OFF_PART_SEL, 32'h7);
    wr(nsp, OFF_CMAX, 32'h11);
    wr(sec, OFF_PART_SEL, 32'h3);
    wr(sec, OFF_CMAX, 32'h22);
    rd(nsp, OFF_CMAX, 32'h11, "cmax ns p7");
    wr(nsp, OFF_PART_SEL, 32'h8);
    rd(nsp, OFF_ESR, 32'h0100_0008, "esr ns");
    rd(sec, OFF_ESR, 32'h0, "esr s");
    rd(nsp, OFF_CMAX, 32'h11, "cmax kept");
    wr(nsp, OFF_PART_SEL, 32'h3);
    rd(nsp, OFF_CMAX, 32'hcd, "cmax ns p3");
    rd(sec, OFF_CMAX, 32'h22, "cmax s p3");
    wr(nsp, OFF_PRI, 32'h5);
    rd(nsp, OFF_PRI, 32'h5, "pri ns");
    wr(sec, OFF_PRI, 32'h5);
    rd(sec, OFF_PRI, 32'h0, "pri s");
    // monitors, banked per space
    wr(nsp, OFF_MON_SEL, 32'h1);
    wr(nsp, OFF_FLT, 32'h0000_0002);
    wr(nsp, OFF_CTL, 32'hf001_0000);
    rd(nsp, OFF_CTL, 32'hf001_0042, "ctl ns m1");
    wr(sec, OFF_MON_SEL, 32'h1);
    wr(sec, OFF_CTL, 32'h8000_0000);
    src_u.beat(nsp, 16'h2, 16'h10);
    src_u.beat(nsp, 16'h3, 16'h20);
    src_u.beat(sec, 16'h2, 16'h7);
    rd(nsp, OFF_CNT, 32'h10, "cnt ns m1");
    rd(sec, OFF_CNT, 32'h7, "cnt s m1");
    wr(nsp, OFF_MON_SEL, 32'h4);
    rd(nsp, OFF_ESR, 32'h0200_0004, "esr mon");
    rd(nsp, OFF_CNT, 32'h10, "cnt kept");
    wr(nsp, OFF_CAPT, 32'h1);
    rd(nsp, OFF_CAPTURE, 32'h10, "capture ns");
    rd(sec, OFF_CAPTURE, 32'h0, "capture s");
    wr(nsp, OFF_MON_SEL, 32'h0);
    rd(nsp, OFF_CNT, 32'h0, "cnt ns m0");
    // error control keeps only its one writable bit, per space
    wr(nsp, OFF_ECR, 32'hffff_ffff);
    rd(nsp, OFF_ECR, 32'h1, "ecr ns mask");
    rd(sec, OFF_ECR, 32'h0, "ecr s");
    // carry out of the count sets the overflow status
    wr(nsp, OFF_MON_SEL, 32'h1);
    wr(nsp, OFF_CNT, 32'hffff_fff8);
    src_u.beat(nsp, 16'h2, 16'h10);
    rd(nsp, OFF_CNT, 32'h8, "cnt wrapped");
    rd(nsp, OFF_CTL, 32'hf401_0042, "ctl overflow");
    // secure capture with the all bit reaches the non-secure monitors too
    wr(sec, OFF_CAPT, 32'h3);
    rd(nsp, OFF_CAPTURE, 32'h8, "capture all");
    rd(sec, OFF_CAPTURE, 32'h0, "capture s off");
    // reserved and absent places
    wr(nsp, 16'h3000, 32'hffff_ffff);
    rd(nsp, 16'h3000, 32'h0, "impl region");
    rd(nsp, 16'h0028, 32'h0, "unallocated");
    wr(sec, OFF_IDR, 32'h0);
    rd(sec, OFF_IDR, IDR_S_VAL, "idr after write");
    acc(1'b0, nsp, 32'h5000_0000, 32'h0, r);
    chk("miss hit", {31'h0, r.hit}, 32'h0);
    chk("miss valid", {31'h0, r.valid}, 32'h1);
    // second reset mid-run clears the settings
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(nsp, OFF_CMAX, 32'h0, "cmax after reset");
    test_done();
  end
endmodule : testbench

bind part_mon_frame frame_asserts chk_u (
  .core_clk(core_clk),
  .rst(rst),
  .req(req),
  .rsp(rsp)
);

// file: testbench/traffic_src.sv
// traffic source standing in for the requesters the monitors watch
`timescale 1ns/10ps
module traffic_src
  import frame_pkg::*;
(
  // clock
  input wire logic core_clk,
  // traffic beats
  output mon_evt_t evt
);
  initial evt = '0;
  // one beat; idle fields scrambled so stale values never look valid
  task automatic beat(input logic sp, input logic [15:0] pid, input logic [15:0] nb);
    @(posedge core_clk);
    evt <= '{valid: 1'b1, ns: sp, partition_identifier: pid, monitoring_group: 8'h00, bytes: nb};
    @(posedge core_clk);
    evt <= '{valid: 1'b0, ns: ~sp, partition_identifier: ~pid, monitoring_group: 8'hff, bytes: ~nb};
  endtask : beat
endmodule : traffic_src
